// >>> dbrcs_cfg.svh
// Constants for the bit rate clock select block.
`ifndef DBRCS_CFG_SVH
`define DBRCS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DBRCS_OFF_CSA      8'h00
`define DBRCS_OFF_CMDA     8'h04
`define DBRCS_OFF_CSB      8'h08
`define DBRCS_OFF_CMDB     8'h0C
`define DBRCS_OFF_AUX      8'h10
`define DBRCS_OFF_TPH      8'h14
`define DBRCS_OFF_TPL      8'h18
`define DBRCS_OFF_OPC      8'h1C
`define DBRCS_OFF_STAT     8'h20

// ----------------------------------------------------------------------
// Command codes and field positions
// ----------------------------------------------------------------------
`define DBRCS_CMD_RX_SET   8'h08
`define DBRCS_CMD_RX_CLR   8'h09
`define DBRCS_CMD_TX_SET   8'h0A
`define DBRCS_CMD_TX_CLR   8'h0B
`define DBRCS_AUX_SET_BIT  7
`define DBRCS_AUX_MODE_HI  6
`define DBRCS_AUX_MODE_LO  4
`define DBRCS_MODE_TIMER   3'h4
`define DBRCS_OPC_OP3_HI   3
`define DBRCS_OPC_OP3_LO   2
`define DBRCS_OPC_OP3_TMR  2'h1
`define DBRCS_CS_TX_HI     3
`define DBRCS_CS_TX_LO     0
`define DBRCS_CS_RX_HI     7
`define DBRCS_CS_RX_LO     4

// ----------------------------------------------------------------------
// Clock source codes, divisors and counts
// ----------------------------------------------------------------------
`define DBRCS_NIB_GEN_MAX  4'hC
`define DBRCS_NIB_TIMER    4'hD
`define DBRCS_NIB_EXT16    4'hE
`define DBRCS_NIB_FAST     4'h8
`define DBRCS_GEN_DIV_FAST 8'h02
`define DBRCS_GEN_DIV_DEF  8'h60
`define DBRCS_MID_COUNT    4'h6
`define DBRCS_BIT_COUNT    4'hF
`define DBRCS_FRAME_BITS   4'hA
`define DBRCS_RESET_BYTE   8'h00
`define DBRCS_RESET_WORD   16'h0000

`endif

// >>> dbrcs_far_model.sv
// Crystal, external clock and remote serial sender around the block.
`timescale 1ns/100ps

module dbrcs_far_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic start_in,
  output logic      crystal_out,
  output logic      ext_clk_out,
  output logic      serial_out
);
  // --------------------------------------------------------------------
  // Free running sources
  // --------------------------------------------------------------------
  // The crystal edges come every four system cycles, below half rate.
  logic       xtal_ph_reg;
  logic [2:0] ext_cnt_reg;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xtal_ph_reg <= 1'h0;
      crystal_out <= 1'h0;
      ext_cnt_reg <= 3'h0;
      ext_clk_out <= 1'h0;
      serial_out  <= 1'h1;
    end else begin
      xtal_ph_reg <= !xtal_ph_reg;
      if (xtal_ph_reg) begin
        crystal_out <= !crystal_out;
      end
      ext_cnt_reg <= (ext_cnt_reg == 3'h4) ? 3'h0 : ext_cnt_reg + 3'h1;
      if (ext_cnt_reg == 3'h4) begin
        ext_clk_out <= !ext_clk_out;
        if (ext_clk_out) begin
          serial_out <= !start_in;
        end
      end
    end
  end
endmodule // dbrcs_far_model

// >>> dbrcs_path.sv
// One receiver or transmitter clock path: source select and bit timing.
`timescale 1ns/100ps
`include "dbrcs_cfg.svh"

module dbrcs_path #(
  parameter bit IS_RX = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic [3:0] nibble_in,
  input  wire logic       rate_set_in,
  input  wire logic       extend_in,
  input  wire logic       xtal_tick_in,
  input  wire logic       timer_wave_in,
  input  wire logic       ext_pin_in,
  input  wire logic       serial_in,
  output logic            tick16_out,
  output logic            bit_tick_out
);

  // --------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------
  dbrcs_pkg::dbrcs_src_type src;
  logic [7:0] gen_div;
  logic [7:0] gen_cnt_reg;
  logic [7:0] gen_cnt_next;
  logic       wave_prev_reg;
  logic       pin_prev_reg;
  logic       gen_hit;
  logic       timer_edge;
  logic       pin_edge;
  logic       tick16;
  logic       one_x;

  assign src        = dbrcs_pkg::src_of(nibble_in);
  assign gen_div    = dbrcs_pkg::gen_div(nibble_in, rate_set_in,
                                         extend_in);
  assign gen_hit    = xtal_tick_in && (gen_cnt_reg >= gen_div - 8'h01);
  assign timer_edge = timer_wave_in && !wave_prev_reg;
  assign pin_edge   = ext_pin_in && !pin_prev_reg;
  assign one_x      = (src == dbrcs_pkg::SRC_EXT1);
  assign gen_cnt_next = !xtal_tick_in ? gen_cnt_reg :
                        gen_hit ? `DBRCS_RESET_BYTE :
                        gen_cnt_reg + 8'h01;

  always_comb begin
    case (src)
      dbrcs_pkg::SRC_GEN:   tick16 = gen_hit;
      dbrcs_pkg::SRC_TIMER: tick16 = timer_edge;
      dbrcs_pkg::SRC_EXT16: tick16 = pin_edge;
      default:              tick16 = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Bit timing
  // --------------------------------------------------------------------
  dbrcs_pkg::dbrcs_rx_type state_reg;
  dbrcs_pkg::dbrcs_rx_type state_next;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [3:0] bits_reg;
  logic [3:0] bits_next;
  logic       bit_next;

  always_comb begin
    state_next = state_reg;
    div_next   = div_reg;
    bits_next  = bits_reg;
    bit_next   = 1'b0;
    if (one_x) begin
      // A 1X clock is used as is, with no divide-by-16.
      bit_next   = pin_edge;
      state_next = dbrcs_pkg::RX_HUNT;
      div_next   = 4'h0;
    end else if (!IS_RX) begin
      if (tick16) begin
        div_next = div_reg + 4'h1;
        bit_next = (div_reg == `DBRCS_BIT_COUNT);
      end
    end else if (tick16) begin
      case (state_reg)
        dbrcs_pkg::RX_HUNT: begin
          div_next = 4'h0;
          if (!serial_in) begin
            state_next = dbrcs_pkg::RX_START;
          end
        end
        dbrcs_pkg::RX_START: begin
          div_next = div_reg + 4'h1;
          if (div_reg == `DBRCS_MID_COUNT) begin
            bit_next   = 1'b1;
            div_next   = 4'h0;
            bits_next  = 4'h1;
            state_next = dbrcs_pkg::RX_DATA;
          end
        end
        dbrcs_pkg::RX_DATA: begin
          div_next = div_reg + 4'h1;
          if (div_reg == `DBRCS_BIT_COUNT) begin
            bit_next  = 1'b1;
            bits_next = bits_reg + 4'h1;
            if (bits_reg + 4'h1 == `DBRCS_FRAME_BITS) begin
              state_next = dbrcs_pkg::RX_HUNT;
            end
          end
        end
        default: begin
          state_next = dbrcs_pkg::RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gen_cnt_reg   <= `DBRCS_RESET_BYTE;
      wave_prev_reg <= 1'b0;
      pin_prev_reg  <= 1'b0;
      state_reg     <= dbrcs_pkg::RX_HUNT;
      div_reg       <= 4'h0;
      bits_reg      <= 4'h0;
      tick16_out    <= 1'b0;
      bit_tick_out  <= 1'b0;
    end else begin
      gen_cnt_reg   <= gen_cnt_next;
      wave_prev_reg <= timer_wave_in;
      pin_prev_reg  <= ext_pin_in;
      state_reg     <= state_next;
      div_reg       <= div_next;
      bits_reg      <= bits_next;
      tick16_out    <= one_x ? pin_edge : tick16;
      bit_tick_out  <= bit_next;
    end
  end

endmodule // dbrcs_path

// >>> dbrcs_pkg.sv
// Types and shared decoding for the bit rate clock select block.
`include "dbrcs_cfg.svh"

package dbrcs_pkg;

  typedef enum logic [1:0] {
    SRC_GEN,
    SRC_TIMER,
    SRC_EXT16,
    SRC_EXT1
  } dbrcs_src_type;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_START,
    RX_DATA
  } dbrcs_rx_type;

  // Maps a clock select nibble onto its timing source.
  function automatic dbrcs_src_type src_of(input logic [3:0] nib);
    if (nib <= `DBRCS_NIB_GEN_MAX) begin
      src_of = SRC_GEN;
    end else if (nib == `DBRCS_NIB_TIMER) begin
      src_of = SRC_TIMER;
    end else if (nib == `DBRCS_NIB_EXT16) begin
      src_of = SRC_EXT16;
    end else begin
      src_of = SRC_EXT1;
    end
  endfunction

  // Crystal edges per 16X tick. Only the fast entry is tabulated; every
  // other code falls back to one default divisor.
  function automatic logic [7:0] gen_div(input logic [3:0] nib,
                                         input logic       set2,
                                         input logic       ext);
    if (nib == `DBRCS_NIB_FAST && set2 && ext) begin
      gen_div = `DBRCS_GEN_DIV_FAST;
    end else begin
      gen_div = `DBRCS_GEN_DIV_DEF;
    end
  endfunction

endpackage

// >>> dbrcs_top.sv
// Bit rate clock select for two channels with a Wishbone register port.
// Behaviour
// - Command 0A sets transmitter extend bit.
// - Command 08 sets receiver extend bit.
// - Control bit seven selects second rate set.
// - Code 88 in set two with the path's extend bit set gives 115.2kbps.
// - Timer wave is crystal over twice preload.
// - Control bits 6:4 = 100 start timer.
// - Code DD clocks channel B from timer/16.
// - Config bits 3:2 = 01 put wave on output three.
// - Code FF on channel A uses input pins three, four as 1X.
// - Nibbles 0 to C select the rate generator.
// - Receiver samples midpoint after 7, then every 16.
`timescale 1ns/100ps
`include "dbrcs_cfg.svh"

module dbrcs_top (
  input  wire logic        MCLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        CRYSTAL_CLOCK_IN,
  input  wire logic        GENERAL_INPUT_THREE_IN,
  input  wire logic        GENERAL_INPUT_FOUR_IN,
  input  wire logic        EXT_RXB_CLK_IN,
  input  wire logic        EXT_TXB_CLK_IN,
  input  wire logic        RXA_SERIAL_IN,
  input  wire logic        RXB_SERIAL_IN,
  output logic             RXA_TICK16_OUT,
  output logic             RXA_SAMPLE_OUT,
  output logic             TXA_TICK16_OUT,
  output logic             TXA_BIT_OUT,
  output logic             RXB_TICK16_OUT,
  output logic             RXB_SAMPLE_OUT,
  output logic             TXB_TICK16_OUT,
  output logic             TXB_BIT_OUT,
  output logic             GENERAL_OUTPUT_THREE_OUT
);

  // --------------------------------------------------------------------
  // Wishbone decode
  // --------------------------------------------------------------------
  logic [7:0]  chan_a_clock_select_reg;
  logic [7:0]  chan_b_clock_select_reg;
  logic [7:0]  aux_control_reg;
  logic [7:0]  timer_preload_high_reg;
  logic [7:0]  timer_preload_low_reg;
  logic [7:0]  output_port_config_reg;
  logic [3:0]  extend_reg;
  logic [3:0]  extend_next;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        req;
  logic        wr;
  logic [7:0]  wbyte;
  logic        wr_csa;
  logic        wr_csb;
  logic        wr_aux;
  logic        wr_tph;
  logic        wr_tpl;
  logic        wr_opc;
  logic        wr_cmda;
  logic        wr_cmdb;
  logic [7:0]  status;

  // The write lands on the same edge the master samples the acknowledge,
  // so a request that is withdrawn early never changes a register.
  assign req     = WB_CYC_IN && WB_STB_IN;
  assign wr      = req && WB_WE_IN && ack_reg && WB_SEL_IN[0];
  assign wbyte   = WB_DAT_IN[7:0];
  assign wr_csa  = wr && (WB_ADR_IN == `DBRCS_OFF_CSA);
  assign wr_csb  = wr && (WB_ADR_IN == `DBRCS_OFF_CSB);
  assign wr_aux  = wr && (WB_ADR_IN == `DBRCS_OFF_AUX);
  assign wr_tph  = wr && (WB_ADR_IN == `DBRCS_OFF_TPH);
  assign wr_tpl  = wr && (WB_ADR_IN == `DBRCS_OFF_TPL);
  assign wr_opc  = wr && (WB_ADR_IN == `DBRCS_OFF_OPC);
  assign wr_cmda = wr && (WB_ADR_IN == `DBRCS_OFF_CMDA);
  assign wr_cmdb = wr && (WB_ADR_IN == `DBRCS_OFF_CMDB);

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = rdata_reg;

  // Extend bits: [0] rx A, [1] tx A, [2] rx B, [3] tx B.
  always_comb begin
    extend_next = extend_reg;
    if (wr_cmda) begin
      case (wbyte)
        `DBRCS_CMD_RX_SET: extend_next[0] = 1'b1;
        `DBRCS_CMD_RX_CLR: extend_next[0] = 1'b0;
        `DBRCS_CMD_TX_SET: extend_next[1] = 1'b1;
        `DBRCS_CMD_TX_CLR: extend_next[1] = 1'b0;
        default:           extend_next    = extend_reg;
      endcase
    end
    if (wr_cmdb) begin
      case (wbyte)
        `DBRCS_CMD_RX_SET: extend_next[2] = 1'b1;
        `DBRCS_CMD_RX_CLR: extend_next[2] = 1'b0;
        `DBRCS_CMD_TX_SET: extend_next[3] = 1'b1;
        `DBRCS_CMD_TX_CLR: extend_next[3] = 1'b0;
        default:           extend_next    = extend_reg;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Counter/timer
  // --------------------------------------------------------------------
  logic        xtal_prev_reg;
  logic        xtal_tick;
  logic        timer_run;
  logic [15:0] preload;
  logic [15:0] tcnt_reg;
  logic [15:0] tcnt_next;
  logic        wave_reg;
  logic        wave_next;
  logic        op3_reg;

  assign xtal_tick = CRYSTAL_CLOCK_IN && !xtal_prev_reg;
  assign timer_run = (aux_control_reg[`DBRCS_AUX_MODE_HI:`DBRCS_AUX_MODE_LO]
                      == `DBRCS_MODE_TIMER);
  assign preload   = {timer_preload_high_reg, timer_preload_low_reg};

  // Half a period is preload crystal edges, so the wave runs at the
  // crystal rate over twice the preload. Zero behaves like one.
  always_comb begin
    tcnt_next = tcnt_reg;
    wave_next = wave_reg;
    if (!timer_run) begin
      tcnt_next = preload;
      wave_next = 1'b0;
    end else if (xtal_tick) begin
      if (tcnt_reg <= 16'h0001) begin
        tcnt_next = preload;
        wave_next = !wave_reg;
      end else begin
        tcnt_next = tcnt_reg - 16'h0001;
      end
    end
  end

  assign GENERAL_OUTPUT_THREE_OUT = op3_reg;

  assign status = {2'h0, op3_reg, wave_reg, extend_reg};

  always_comb begin
    case (WB_ADR_IN)
      `DBRCS_OFF_CSA:  rdata_next = {24'h000000, chan_a_clock_select_reg};
      `DBRCS_OFF_CSB:  rdata_next = {24'h000000, chan_b_clock_select_reg};
      `DBRCS_OFF_AUX:  rdata_next = {24'h000000, aux_control_reg};
      `DBRCS_OFF_TPH:  rdata_next = {24'h000000, timer_preload_high_reg};
      `DBRCS_OFF_TPL:  rdata_next = {24'h000000, timer_preload_low_reg};
      `DBRCS_OFF_OPC:  rdata_next = {24'h000000, output_port_config_reg};
      `DBRCS_OFF_STAT: rdata_next = {24'h000000, status};
      default:         rdata_next = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_reg                 <= 1'b0;
      rdata_reg               <= 32'h00000000;
      chan_a_clock_select_reg <= `DBRCS_RESET_BYTE;
      chan_b_clock_select_reg <= `DBRCS_RESET_BYTE;
      aux_control_reg         <= `DBRCS_RESET_BYTE;
      timer_preload_high_reg  <= `DBRCS_RESET_BYTE;
      timer_preload_low_reg   <= `DBRCS_RESET_BYTE;
      output_port_config_reg  <= `DBRCS_RESET_BYTE;
      extend_reg              <= 4'h0;
    end else begin
      ack_reg   <= req && !ack_reg;
      rdata_reg <= (req && !ack_reg) ? rdata_next : 32'h00000000;
      if (wr_csa) chan_a_clock_select_reg <= wbyte;
      if (wr_csb) chan_b_clock_select_reg <= wbyte;
      if (wr_aux) aux_control_reg <= wbyte;
      if (wr_tph) timer_preload_high_reg <= wbyte;
      if (wr_tpl) timer_preload_low_reg <= wbyte;
      if (wr_opc) output_port_config_reg <= wbyte;
      extend_reg <= extend_next;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      xtal_prev_reg <= 1'b0;
      tcnt_reg      <= `DBRCS_RESET_WORD;
      wave_reg      <= 1'b0;
      op3_reg       <= 1'b0;
    end else begin
      xtal_prev_reg <= CRYSTAL_CLOCK_IN;
      tcnt_reg      <= tcnt_next;
      wave_reg      <= wave_next;
      op3_reg       <= (output_port_config_reg[`DBRCS_OPC_OP3_HI:
                        `DBRCS_OPC_OP3_LO] == `DBRCS_OPC_OP3_TMR)
                       && wave_reg;
    end
  end

  // --------------------------------------------------------------------
  // Clock paths: 0 rx A, 1 tx A, 2 rx B, 3 tx B
  // --------------------------------------------------------------------
  logic [3:0] nib [4];
  logic [3:0] pin;
  logic [3:0] ser;
  logic [3:0] t16;
  logic [3:0] bt;

  assign nib[0] = chan_a_clock_select_reg[`DBRCS_CS_RX_HI:`DBRCS_CS_RX_LO];
  assign nib[1] = chan_a_clock_select_reg[`DBRCS_CS_TX_HI:`DBRCS_CS_TX_LO];
  assign nib[2] = chan_b_clock_select_reg[`DBRCS_CS_RX_HI:`DBRCS_CS_RX_LO];
  assign nib[3] = chan_b_clock_select_reg[`DBRCS_CS_TX_HI:`DBRCS_CS_TX_LO];
  // The 1X receive clock assumes the far sender is synchronous to it.
  assign pin = {EXT_TXB_CLK_IN, EXT_RXB_CLK_IN,
                GENERAL_INPUT_THREE_IN, GENERAL_INPUT_FOUR_IN};
  assign ser = {1'b1, RXB_SERIAL_IN, 1'b1, RXA_SERIAL_IN};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_path
      dbrcs_path #(
        .IS_RX ((i % 2) == 0)
      ) u_path (
        .clk_in        (MCLK_IN),
        .rstn_in       (RSTN_IN),
        .nibble_in     (nib[i]),
        .rate_set_in   (aux_control_reg[`DBRCS_AUX_SET_BIT]),
        .extend_in     (extend_reg[i]),
        .xtal_tick_in  (xtal_tick),
        .timer_wave_in (wave_reg),
        .ext_pin_in    (pin[i]),
        .serial_in     (ser[i]),
        .tick16_out    (t16[i]),
        .bit_tick_out  (bt[i])
      );
    end
  endgenerate

  assign RXA_TICK16_OUT = t16[0];
  assign RXA_SAMPLE_OUT = bt[0];
  assign TXA_TICK16_OUT = t16[1];
  assign TXA_BIT_OUT    = bt[1];
  assign RXB_TICK16_OUT = t16[2];
  assign RXB_SAMPLE_OUT = bt[2];
  assign TXB_TICK16_OUT = t16[3];
  assign TXB_BIT_OUT    = bt[3];

endmodule // dbrcs_top

// >>> dbrcs_top_asserts.sv
// Concurrent checks on the ports of the bit rate clock select block.
`timescale 1ns/100ps
`include "dbrcs_cfg.svh"

module dbrcs_top_asserts (
  input wire logic        MCLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        RXA_TICK16_OUT,
  input wire logic        RXA_SAMPLE_OUT,
  input wire logic        TXA_TICK16_OUT,
  input wire logic        TXA_BIT_OUT,
  input wire logic        TXB_TICK16_OUT,
  input wire logic        TXB_BIT_OUT,
  input wire logic        GENERAL_OUTPUT_THREE_OUT
);
  // --------------------------------------------------------------------
  // Output three selection as last written
  // --------------------------------------------------------------------
  logic opc_sel_reg;
  logic opc_sel_next;
  logic opc_wr;
  logic quiet_rd;

  assign opc_wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT &&
                  WB_SEL_IN[0] && WB_ADR_IN == `DBRCS_OFF_OPC;
  assign opc_sel_next = opc_wr ? WB_DAT_IN[3:2] == `DBRCS_OPC_OP3_TMR
                               : opc_sel_reg;
  assign quiet_rd = WB_ADR_IN == `DBRCS_OFF_CMDA ||
                    WB_ADR_IN == `DBRCS_OFF_CMDB ||
                    WB_ADR_IN > `DBRCS_OFF_STAT;

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      opc_sel_reg <= 1'h0;
    end else begin
      opc_sel_reg <= opc_sel_next;
    end
  end

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_ack_follows_req: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
    |=> WB_ACK_OUT) else $error("ack missing after request");
  a_ack_has_cause: assert property (WB_ACK_OUT |->
    $past(WB_CYC_IN && WB_STB_IN)) else $error("ack without request");
  a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  a_rdata_idle_zero: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("read data not zero outside ack");
  a_quiet_read_zero: assert property (WB_ACK_OUT && !WB_WE_IN && quiet_rd
    |-> WB_DAT_OUT == 32'h0) else $error("write only place read nonzero");
  a_txa_tick_pulse: assert property (TXA_TICK16_OUT |=> !TXA_TICK16_OUT)
    else $error("tx A tick longer than one cycle");
  a_txa_bit_tick: assert property (TXA_BIT_OUT |-> TXA_TICK16_OUT)
    else $error("tx A bit without tick");
  a_txb_bit_tick: assert property (TXB_BIT_OUT |-> TXB_TICK16_OUT)
    else $error("tx B bit without tick");
  a_rxa_sample_tick: assert property (RXA_SAMPLE_OUT |-> RXA_TICK16_OUT)
    else $error("rx A sample without tick");
  a_rxa_sample_gap: assert property (RXA_SAMPLE_OUT |=>
    !RXA_SAMPLE_OUT [*8]) else $error("rx A samples too close");
  a_op3_gated_off: assert property (!opc_sel_reg [*3] |->
    !GENERAL_OUTPUT_THREE_OUT) else $error("output three not gated");

  c_write_done: cover property (WB_ACK_OUT && WB_WE_IN);
  c_op3_rise: cover property ($rose(GENERAL_OUTPUT_THREE_OUT));
  c_rxa_sample: cover property (RXA_SAMPLE_OUT);
  c_txb_bit: cover property (TXB_BIT_OUT);
endmodule // dbrcs_top_asserts

bind dbrcs_top dbrcs_top_asserts i_chk (.MCLK_IN, .RSTN_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT,
  .WB_ACK_OUT, .RXA_TICK16_OUT, .RXA_SAMPLE_OUT, .TXA_TICK16_OUT,
  .TXA_BIT_OUT, .TXB_TICK16_OUT, .TXB_BIT_OUT, .GENERAL_OUTPUT_THREE_OUT);

// >>> dbrcs_top_tb.sv
// Self-checking bench for the bit rate clock select block.
`timescale 1ns/100ps
`include "dbrcs_cfg.svh"

module dbrcs_top_tb;
  localparam int XT = 4;
  localparam int EXT = 10;
  logic        mclk = 1'h0;
  logic        rstn = 1'h0;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic        start = 1'h0;
  logic        rxb_ser = 1'h1;
  logic [31:0] rdat;
  logic        ack;
  logic        xtal;
  logic        ext_clk;
  logic        rxa_ser;
  wire logic [8:0] outs;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #10 mclk = ~mclk;

  dbrcs_far_model i_far (.clk_in(mclk), .rstn_in(rstn), .start_in(start),
    .crystal_out(xtal), .ext_clk_out(ext_clk), .serial_out(rxa_ser));

  dbrcs_top i_dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .CRYSTAL_CLOCK_IN(xtal), .GENERAL_INPUT_THREE_IN(ext_clk),
    .GENERAL_INPUT_FOUR_IN(outs[8]), .EXT_RXB_CLK_IN(ext_clk),
    .EXT_TXB_CLK_IN(ext_clk), .RXA_SERIAL_IN(rxa_ser),
    .RXB_SERIAL_IN(rxb_ser), .RXA_TICK16_OUT(outs[0]),
    .RXA_SAMPLE_OUT(outs[1]), .TXA_TICK16_OUT(outs[2]),
    .TXA_BIT_OUT(outs[3]), .RXB_TICK16_OUT(outs[4]),
    .RXB_SAMPLE_OUT(outs[5]), .TXB_TICK16_OUT(outs[6]),
    .TXB_BIT_OUT(outs[7]), .GENERAL_OUTPUT_THREE_OUT(outs[8]));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The slave may take up to 20 edges; the acknowledge or that bound ends a wait.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (ack !== 1'h1) begin
      chk("ack", 32'h1, 32'h0);
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'h1, a, d, r);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'h0, a, 8'h00, r);
    chk(nm, exp, r);
  endtask

  // Counts rising edges of one output over a window; gap is the last one.
  task automatic scan(input int idx, input int win, output int cnt,
                      output int first, output int gap);
    int last;
    logic prev;
    cnt = 0;
    first = 0;
    gap = 0;
    last = 0;
    prev = 1'h1;
    for (int t = 1; t <= win; t++) begin
      @(posedge mclk);
      if (outs[idx] === 1'h1 && prev !== 1'h1) begin
        if (cnt == 0) first = t;
        else gap = t - last;
        last = t;
        cnt++;
      end
      prev = outs[idx];
    end
  endtask

  task automatic gap_chk(input string nm, input int idx, input int win,
                         input int exp);
    int c;
    int f;
    int g;
    scan(idx, win, c, f, g);
    chk(nm, exp, g);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int c;
    int f;
    int g;
    logic [7:0] cadr [8] = '{8'h04, 8'h04, 8'h0C, 8'h0C,
                             8'h04, 8'h04, 8'h0C, 8'h0C};
    logic [7:0] cmd [8] = '{8'h0A, 8'h08, 8'h08, 8'h0A,
                            8'h09, 8'h0B, 8'h09, 8'h0B};
    logic [7:0] st [8] = '{8'h02, 8'h03, 8'h07, 8'h0F,
                           8'h0E, 8'h0C, 8'h08, 8'h00};
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    for (int a = 0; a <= 'h24; a += 4) rd_chk("reset", a[7:0], 32'h0);
    wr(8'h80, 8'h5A);
    rd_chk("unmapped", 8'h80, 32'h0);
    sel <= 4'h0;
    wr(`DBRCS_OFF_AUX, 8'hFF);
    sel <= 4'hF;
    rd_chk("sel_off", `DBRCS_OFF_AUX, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(cadr[i], cmd[i]);
      rd_chk("ext_bits", `DBRCS_OFF_STAT, {24'h0, st[i]});
    end
    wr(`DBRCS_OFF_CMDA, `DBRCS_CMD_TX_SET);
    wr(`DBRCS_OFF_AUX, 8'h80);
    wr(`DBRCS_OFF_CSA, 8'h88);
    rd_chk("csa", `DBRCS_OFF_CSA, 32'h88);
    gap_chk("txa_fast", 2, 100, 2 * XT);
    gap_chk("rxa_slow", 0, 1200, 96 * XT);
    wr(`DBRCS_OFF_CMDA, `DBRCS_CMD_RX_SET);
    gap_chk("rxa_fast", 0, 100, 2 * XT);
    wr(`DBRCS_OFF_AUX, 8'h00);
    gap_chk("txa_set1", 2, 1200, 96 * XT);
    wr(`DBRCS_OFF_AUX, 8'h80);
    for (int n = 0; n <= 'hC; n++) begin
      wr(`DBRCS_OFF_CSA, {n[3:0], n[3:0]});
      gap_chk("gen", 2, 1200, (n == 8) ? 2 * XT : 96 * XT);
    end
    wr(`DBRCS_OFF_CSA, 8'h88);
    start <= 1'h1;
    fork
      begin
        repeat (20) @(posedge mclk);
        start <= 1'h0;
      end
      scan(1, 1600, c, f, g);
    join
    chk("samples", 10, c);
    chk("sample_gap", 16 * 2 * XT, g);
    chk("first_sample", 1, f >= 56 && f <= 80);
    wr(`DBRCS_OFF_TPH, 8'h00);
    wr(`DBRCS_OFF_TPL, 8'h02);
    wr(`DBRCS_OFF_AUX, 8'hC0);
    scan(8, 100, c, f, g);
    chk("op3_off", 0, c);
    wr(`DBRCS_OFF_OPC, 8'h04);
    for (int p = 2; p <= 3; p++) begin
      wr(`DBRCS_OFF_TPL, p[7:0]);
      gap_chk("op3_wave", 8, 300, 2 * p * XT);
    end
    wr(`DBRCS_OFF_AUX, 8'hB0);
    scan(8, 200, c, f, g);
    chk("timer_off", 0, c);
    chk("op3_low", 0, outs[8]);
    wr(`DBRCS_OFF_TPL, 8'h02);
    wr(`DBRCS_OFF_AUX, 8'hC0);
    wr(`DBRCS_OFF_CSB, 8'hDD);
    gap_chk("rxb_tick", 4, 200, 4 * XT);
    gap_chk("txb_tick", 6, 200, 4 * XT);
    gap_chk("txb_bit", 7, 800, 16 * 4 * XT);
    rxb_ser <= 1'h0;
    scan(5, 400, c, f, g);
    rxb_ser <= 1'h1;
    chk("rxb_first", 1, f >= 112 && f <= 130);
    chk("rxb_gap", 16 * 4 * XT, g);
    wr(`DBRCS_OFF_CSA, 8'hFF);
    gap_chk("txa_1x", 2, 100, EXT);
    gap_chk("txa_bit_1x", 3, 100, EXT);
    gap_chk("rxa_1x", 0, 100, 4 * XT);
    final_report();
  end
endmodule // dbrcs_top_tb
